/* File: dv/plc_cmd_source.sv */
// Controller model: one command at a time, write or sync.
// Assumes send is not called again before it returns.
module plc_cmd_source
    import match_cmd_pkg::*;
(
    input  wire logic   CLK, ACK_VALID,
    output logic        START, BYTE_VALID, BYTE_LAST, USER_DATA_OK,
    output logic [7:0]  PCB_CODE, BUFFER_OFFSET, TAG_IDENTIFIER, BYTE_DATA,
    output logic [15:0] START_LOCATION, DECLARED_LEN, USER_DATA_LEN
);
    initial {START, BYTE_VALID, BYTE_LAST, USER_DATA_OK, PCB_CODE, BUFFER_OFFSET} = '0;
    initial {TAG_IDENTIFIER, BYTE_DATA, START_LOCATION, DECLARED_LEN, USER_DATA_LEN} = '0;
    task automatic send(input logic [7:0] code, input logic [15:0] len, udl,
                        input logic ok, input logic [7:0] tag, input logic [7:0] b[$]);
        int n;
        n = 0;
        @(posedge CLK);
        START <= 1'b1;
        PCB_CODE <= code;
        TAG_IDENTIFIER <= tag;
        {DECLARED_LEN, USER_DATA_LEN, USER_DATA_OK} <= {len, udl, ok};
        foreach (b[i]) begin
            @(posedge CLK);
            BYTE_VALID <= 1'b1;
            BYTE_DATA <= b[i];
            BYTE_LAST <= (i == b.size() - 1);
        end
        @(posedge CLK);
        {BYTE_VALID, BYTE_LAST} <= 2'h0;
        // Idle data line scrambled so stale bytes never look valid
        BYTE_DATA <= ~BYTE_DATA;
        do @(posedge CLK); while (ACK_VALID !== 1'b1 && ++n < 50);
        START <= 1'b0;
        @(posedge CLK);
    endtask
endmodule

/* File: dv/reader_match_inhibit_cmds_bench.sv */
// Self-checking bench for the command decoder.
// Assumes the controller model drives the command side.
module reader_match_inhibit_cmds_bench;
    import match_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RST_N = 0, STEP_IS_TEXT = 0, FILTER_SRC_OK = 1;
    logic PROG_CHANGE_BEGIN = 0, PROG_CHANGE_END = 0;
    logic START, BYTE_VALID, BYTE_LAST, USER_DATA_OK, ACK_VALID, ACK_POSITIVE;
    logic PROCESSING_INHIBIT_FLAG, READBACK_ARMED, SYNC_MATCH_STROBE;
    logic [7:0] PCB_CODE, BUFFER_OFFSET, TAG_IDENTIFIER, BYTE_DATA, b[$];
    logic [15:0] START_LOCATION, DECLARED_LEN, USER_DATA_LEN;
    logic [3:0] exp_q[$];
    int n_mismatch = 0, cmp_count = 0, cycles = 0, n;
    reader_match_inhibit_cmds dut (.*);
    plc_cmd_source plc (.*);
    initial forever #20 CLK = ~CLK;
    task automatic check(input string what, input logic [3:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        // An answer that never came leaves its note behind
        if (exp_q.size() != 0) n_mismatch++;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] code, input logic [15:0] len, udl,
                       input logic ok, input logic [7:0] tag, input logic [3:0] exp);
        exp_q.push_back(exp);
        plc.send(code, len, udl, ok, tag, b);
    endtask
    task automatic wr(input logic [7:0] id, input logic [15:0] len, input logic [7:0] tag,
                      input logic [3:0] exp);
        b = '{id};
        if (len > 16'h0001) b.push_back(8'h00);
        cmd(PCB_CODE_WRITE, len, 16'h0000, 1'b1, tag, exp);
    endtask
    task automatic pulse(input logic last);
        @(posedge CLK);
        {PROG_CHANGE_BEGIN, PROG_CHANGE_END} <= {!last, last};
        @(posedge CLK);
        {PROG_CHANGE_BEGIN, PROG_CHANGE_END} <= 2'h0;
        repeat (3) @(posedge CLK);
    endtask
    always @(posedge CLK) begin
        // Expected bits: positive, inhibit, strobe, armed
        if (ACK_VALID === 1'b1)
            check("answer", {ACK_POSITIVE, PROCESSING_INHIBIT_FLAG, SYNC_MATCH_STROBE,
                  READBACK_ARMED}, exp_q.pop_front());
        if (++cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        n = $urandom(86);
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        wr(CMD_READ_MATCH, 16'h0001, 8'h00, 4'h9);
        wr(CMD_SET_INHIBIT, 16'h0001, 8'h00, 4'hC);
        wr(CMD_SET_INHIBIT, 16'h0001, 8'h00, 4'hC);
        wr(CMD_SET_INHIBIT, 16'h0002, 8'h00, 4'h4);
        wr(CMD_CLR_INHIBIT, 16'h0001, 8'h00, 4'h8);
        wr(CMD_CLR_INHIBIT, 16'h0001, 8'h00, 4'h8);
        wr(CMD_READ_MATCH, 16'h0002, 8'h00, 4'h0);
        wr(8'h09, 16'h0001, 8'h00, 4'h0);
        wr(CMD_SET_INHIBIT, 16'h0001, 8'h01, 4'h0);
        for (int k = 0; k < 6; k++) begin
            n = 1 + $urandom % 6;
            b = '{CMD_SYNC_MATCH, (k == 2) ? 8'h01 : SYNC_RESERVED_VAL};
            repeat (n) b.push_back(8'($urandom));
            @(posedge CLK);
            {STEP_IS_TEXT, FILTER_SRC_OK} <= {k > 3, k != 4};
            cmd(PCB_CODE_SYNC, 16'(n + 4 + (k == 1)), 16'(n), k != 3, 8'h00,
                (k == 0 || k == 5) ? 4'hA : 4'h0);
        end
        b = '{CMD_SYNC_MATCH};
        cmd(PCB_CODE_SYNC, 16'h0004, 16'h0000, 1'b1, 8'h00, 4'h0);
        b = '{CMD_SET_INHIBIT};
        cmd(PCB_CODE_SYNC, 16'h0001, 16'h0000, 1'b1, 8'h00, 4'h0);
        for (int m = 0; m < 2; m++) begin
            pulse(1'b0);
            check("auto inhibit", {3'h0, PROCESSING_INHIBIT_FLAG}, 4'h1);
            pulse(1'b1);
            check("inhibit after", {3'h0, PROCESSING_INHIBIT_FLAG}, 4'(m));
            wr(CMD_SET_INHIBIT, 16'h0001, 8'h00, 4'hC);
        end
        conclude();
    end
endmodule
bind reader_match_inhibit_cmds reader_match_inhibit_cmds_monitor #(.LEN_W(LEN_W)) mon (.*);

/* File: dv/reader_match_inhibit_cmds_monitor.sv */
// Port checker for the command decoder.
// Assumes binding to the decoder top, LEN_W passed on.
module reader_match_inhibit_cmds_monitor
    import match_cmd_pkg::*;
#(parameter int LEN_W = 16) (
    input wire logic             CLK, RST_N, START, BYTE_VALID, BYTE_LAST, USER_DATA_OK,
    input wire logic             STEP_IS_TEXT, FILTER_SRC_OK,
    input wire logic             PROG_CHANGE_BEGIN, PROG_CHANGE_END, ACK_VALID, ACK_POSITIVE,
    input wire logic             PROCESSING_INHIBIT_FLAG, READBACK_ARMED, SYNC_MATCH_STROBE,
    input wire logic [7:0]       PCB_CODE, BUFFER_OFFSET, TAG_IDENTIFIER,
    input wire logic [15:0]      START_LOCATION,
    input wire logic [LEN_W-1:0] DECLARED_LEN, USER_DATA_LEN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire ack_sync = ACK_VALID && PCB_CODE == PCB_CODE_SYNC;
    chk_ack_latency: assert property (START && BYTE_VALID && BYTE_LAST |-> ##2 ACK_VALID)
        else $error("answer late");
    chk_short_len: assert property (ACK_VALID && PCB_CODE == PCB_CODE_WRITE &&
        DECLARED_LEN != SHORT_CMD_LEN |-> !ACK_POSITIVE) else $error("bad length accepted");
    chk_sync_len: assert property (ack_sync &&
        DECLARED_LEN != USER_DATA_LEN + SYNC_HDR_EXTRA |-> !ACK_POSITIVE) else $error("sync len");
    chk_sync_struct: assert property (ack_sync && !USER_DATA_OK |-> !ACK_POSITIVE)
        else $error("bad user data accepted");
    chk_text_filter: assert property (ack_sync && STEP_IS_TEXT && !FILTER_SRC_OK
        |-> !ACK_POSITIVE) else $error("text filter ignored");
    chk_zero_fields: assert property (ACK_VALID &&
        (BUFFER_OFFSET | TAG_IDENTIFIER | START_LOCATION) != 0 |-> !ACK_POSITIVE) else $error("field");
    chk_strobe_pair: assert property (SYNC_MATCH_STROBE |-> ack_sync && ACK_POSITIVE)
        else $error("stray strobe");
    chk_flag_cause: assert property ($changed(PROCESSING_INHIBIT_FLAG) |-> ACK_POSITIVE ||
        PROG_CHANGE_BEGIN || PROG_CHANGE_END || $past(PROG_CHANGE_BEGIN || PROG_CHANGE_END))
        else $error("flag moved alone");
    chk_armed_cause: assert property ($rose(READBACK_ARMED) |-> ACK_VALID && ACK_POSITIVE)
        else $error("armed alone");
    chk_auto_inhibit: assert property (PROG_CHANGE_BEGIN |-> ##[0:2] PROCESSING_INHIBIT_FLAG)
        else $error("no auto inhibit");
    cov_sync: cover property (SYNC_MATCH_STROBE);
    cov_neg: cover property (ACK_VALID && !ACK_POSITIVE);
    cov_armed: cover property ($rose(READBACK_ARMED));
endmodule

/* File: hdl/reader_match_inhibit_cmds.sv */
// Command decoder for match-string readback, inhibit flag and synced match frames.
// Assumes the controller side is logic on CLK presenting one byte per BYTE_VALID cycle,
// with the profile command block held stable from START until the answer.
//
// Summary of operation
// - Identifier 0x04 only arms a later match-string readback; no string returned.
// - Identifiers 0x04, 0x05, 0x06 answer negatively unless declared length is one.
// - Identifier 0x05 sets the inhibit flag and answers positively; stays set.
// - Identifier 0x06 clears the inhibit flag; answers positively even if already clear.
// - Synced match frame: byte0 is 0x07, byte1 reserved 0x00, then user data.
// - Synced match rejected unless declared length equals user data length plus four.
// - Synced match positive only when header and user data structure are correct.
// - Text-step match accepted only with fixed-text or character-type filter source.
// - Code steps accept all four comparison options for a sent match string.
// - Program change sets inhibit automatically, then clears it unless set manually.
module reader_match_inhibit_cmds
    import match_cmd_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic             START,
    input  wire logic [7:0]       PCB_CODE,
    input  wire logic [7:0]       BUFFER_OFFSET,
    input  wire logic [7:0]       TAG_IDENTIFIER,
    input  wire logic [15:0]      START_LOCATION,
    input  wire logic [LEN_W-1:0] DECLARED_LEN,
    input  wire logic             BYTE_VALID,
    input  wire logic [7:0]       BYTE_DATA,
    input  wire logic             BYTE_LAST,
    input  wire logic [LEN_W-1:0] USER_DATA_LEN,
    input  wire logic             USER_DATA_OK,
    input  wire logic             STEP_IS_TEXT,
    input  wire logic             FILTER_SRC_OK,
    input  wire logic             PROG_CHANGE_BEGIN,
    input  wire logic             PROG_CHANGE_END,
    output logic                  ACK_VALID,
    output logic                  ACK_POSITIVE,
    output logic                  PROCESSING_INHIBIT_FLAG,
    output logic                  READBACK_ARMED,
    output logic                  SYNC_MATCH_STROBE
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    dec_state_t       state;
    dec_state_t       next_state;
    logic [7:0]       ident;
    logic [LEN_W-1:0] count;
    logic             hdr_ok;
    logic             manual_inhibit;
    logic             auto_inhibit;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic ident_is(input logic [7:0] id, input logic [7:0] cmd);
        return id == cmd;
    endfunction

    // One extra bit so a huge user data length cannot wrap into a match
    function automatic logic len_matches(input logic [LEN_W-1:0] declared,
                                         input logic [LEN_W-1:0] payload,
                                         input logic [LEN_W-1:0] extra);
        logic [LEN_W:0] total;
        total = {1'b0, payload} + {1'b0, extra};
        return total == {1'b0, declared};
    endfunction

    // ----------------------------------------------------------------
    // Command checks
    // ----------------------------------------------------------------
    wire id_read     = ident_is(ident, CMD_READ_MATCH);
    wire id_set      = ident_is(ident, CMD_SET_INHIBIT);
    wire id_clr      = ident_is(ident, CMD_CLR_INHIBIT);
    wire id_sync     = ident_is(ident, CMD_SYNC_MATCH);
    wire zero_fields = (BUFFER_OFFSET == ZERO_FIELD[7:0]) && (TAG_IDENTIFIER == ZERO_FIELD[7:0])
                       && (START_LOCATION == ZERO_FIELD);
    wire len_one     = len_matches(DECLARED_LEN, COUNT_RESET[LEN_W-1:0],
                                   SHORT_CMD_LEN[LEN_W-1:0]);
    wire is_short    = id_read || id_set || id_clr;
    wire code_short  = (PCB_CODE == PCB_CODE_WRITE);
    wire code_sync   = (PCB_CODE == PCB_CODE_SYNC);
    wire sync_len_ok = len_matches(DECLARED_LEN, USER_DATA_LEN,
                                   SYNC_HDR_EXTRA[LEN_W-1:0]);
    // Both header bytes must have arrived, a matching length alone is not enough
    wire hdr_full    = (count > SHORT_CMD_LEN[LEN_W-1:0]);
    wire filter_ok   = !STEP_IS_TEXT || FILTER_SRC_OK;
    wire short_ok    = is_short && code_short && len_one && zero_fields;
    wire sync_ok     = id_sync && code_sync && hdr_ok && hdr_full && sync_len_ok
                       && USER_DATA_OK && filter_ok && zero_fields;
    wire cmd_ok      = short_ok || sync_ok;
    wire body_end    = BYTE_VALID && BYTE_LAST;
    wire take_start  = (state == ST_IDLE) && START;
    wire take_byte   = (state == ST_BODY) && BYTE_VALID;
    wire at_ident    = (count == COUNT_RESET[LEN_W-1:0]);
    wire at_reserved = (count == SHORT_CMD_LEN[LEN_W-1:0]);
    wire bad_reserve = at_reserved && id_sync && (BYTE_DATA != SYNC_RESERVED_VAL);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (START) next_state = ST_BODY;
            ST_BODY: if (body_end) next_state = ST_DONE;
            ST_DONE: next_state = ST_WAIT;
            // Held until START drops, so one command never gets two answers
            ST_WAIT: if (!START) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Frame capture
    // ----------------------------------------------------------------
    // Position saturates past the header so a long frame never revisits byte 0 or 1
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count <= COUNT_RESET[LEN_W-1:0];
        end else if (take_start) begin
            count <= COUNT_RESET[LEN_W-1:0];
        end else if (take_byte && !hdr_full) begin
            count <= count + {{(LEN_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ident <= 8'h00;
        end else if (take_byte && at_ident) begin
            ident <= BYTE_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hdr_ok <= 1'b0;
        end else if (take_start) begin
            hdr_ok <= 1'b1;
        end else if (take_byte && bad_reserve) begin
            hdr_ok <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Answer
    // ----------------------------------------------------------------
    wire done   = (state == ST_DONE);
    wire do_set = done && cmd_ok && id_set;
    wire do_clr = done && cmd_ok && id_clr;
    wire do_arm = done && cmd_ok && id_read;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ACK_VALID    <= 1'b0;
            ACK_POSITIVE <= 1'b0;
        end else begin
            ACK_VALID    <= done;
            ACK_POSITIVE <= done && cmd_ok;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SYNC_MATCH_STROBE <= 1'b0;
        end else begin
            SYNC_MATCH_STROBE <= done && sync_ok;
        end
    end

    // Armed until the next answered command; the read itself is served elsewhere
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            READBACK_ARMED <= 1'b0;
        end else if (do_arm) begin
            READBACK_ARMED <= 1'b1;
        end else if (done) begin
            READBACK_ARMED <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Inhibit flag
    // ----------------------------------------------------------------
    // Causes kept apart so a program change never clears a manual set
    wire next_manual = do_set || (manual_inhibit && !do_clr);
    // Begin wins over end when both arrive together
    wire next_auto   = PROG_CHANGE_BEGIN || (auto_inhibit && !PROG_CHANGE_END);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            manual_inhibit <= INHIBIT_RESET;
        end else begin
            manual_inhibit <= next_manual;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            auto_inhibit <= INHIBIT_RESET;
        end else begin
            auto_inhibit <= next_auto;
        end
    end

    // Registered from the next values so the pin moves in step with both causes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PROCESSING_INHIBIT_FLAG <= INHIBIT_RESET;
        end else begin
            PROCESSING_INHIBIT_FLAG <= next_manual || next_auto;
        end
    end

endmodule

/* File: pkg/match_cmd_pkg.sv */
// Constants for the match-string and inhibit command decoder.
// Assumes one clock domain and a byte-serial command stream from the controller link.
package match_cmd_pkg;

    // ----------------------------------------------------------------
    // Command identifiers
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_MATCH    = 8'h04;
    localparam logic [7:0] CMD_SET_INHIBIT   = 8'h05;
    localparam logic [7:0] CMD_CLR_INHIBIT   = 8'h06;
    localparam logic [7:0] CMD_SYNC_MATCH    = 8'h07;
    localparam logic [7:0] SYNC_RESERVED_VAL = 8'h00;

    // ----------------------------------------------------------------
    // Profile command block values
    // ----------------------------------------------------------------
    localparam logic [7:0]  PCB_CODE_WRITE   = 8'h71;
    localparam logic [7:0]  PCB_CODE_SYNC    = 8'h70;
    localparam logic [15:0] SHORT_CMD_LEN    = 16'h0001;
    localparam logic [15:0] SYNC_HDR_EXTRA   = 16'h0004;
    localparam logic [15:0] ZERO_FIELD       = 16'h0000;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic        INHIBIT_RESET    = 1'b0;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BODY = 4'b0010,
        ST_DONE = 4'b0100,
        ST_WAIT = 4'b1000
    } dec_state_t;

endpackage
